// ==== hw/pfs_defs.vh ====
// Offsets, field positions and reset values of the fault status bank
`ifndef PFS_DEFS_VH
`define PFS_DEFS_VH
`define PFS_OFF_BYTE 8'h78
`define PFS_OFF_WORD 8'h79
`define PFS_OFF_VOUT 8'h7a
`define PFS_OFF_IOUT 8'h7b
`define PFS_OFF_INPUT 8'h7c
`define PFS_OFF_TEMP 8'h7d
`define PFS_OFF_CML 8'h7e
`define PFS_RST_BYTE 8'h00
`define PFS_RST_WORD 16'h0000
// Summary word high byte
`define PFS_W_VOUT 15
`define PFS_W_IOUT 14
`define PFS_W_VIN 13
`define PFS_W_VENDOR 12
`define PFS_W_PG_N 11
`define PFS_W_OTHER 8
// Byte-wide summary
`define PFS_B_OFF 6
`define PFS_B_VOUT_OV 5
`define PFS_B_IOUT_OC 4
`define PFS_B_OT 2
`define PFS_B_CML 1
`define PFS_B_NONE 0
// Output voltage byte
`define PFS_V_OV 7
`define PFS_V_UV 4
`define PFS_V_MAXMIN 3
`define PFS_V_OTHER 0
// Current byte
`define PFS_I_OC 7
`define PFS_I_OC_UV 6
`define PFS_I_WARN 5
// Input byte
`define PFS_N_OV_PIN 7
`define PFS_N_HIGH 6
`define PFS_N_LOW 5
// Temperature byte
`define PFS_T_FAULT 7
`define PFS_T_WARN 6
// Communication / memory byte
`define PFS_C_CMD 7
`define PFS_C_DATA 6
`define PFS_C_MEM 4
`define PFS_C_OTHER 1
`define PFS_C_BUSY 0
`endif

// ==== hw/pfs_status_bank.v ====
// Fault and warning status register bank of the power module
// Latched flags only drop on a clear-faults pulse with the cause gone;
// a live cause re-sets them in the same cycle, so set wins over clear.
// Read data lags the address by one cycle; unmapped codes read zero.
// Alert stays low while any latched input or thermal flag or the overcurrent fault flag is up.
`default_nettype none
`include "pfs_defs.vh"

module pfs_status_bank #(
  parameter VIN_W = 10 // Width of measured input voltage
) (
  input wire i_clk, // 200 MHz clock
  input wire i_rst_b, // Async reset, active low
  input wire i_clear_faults, // Clear-faults command pulse
  input wire [7:0] i_rd_addr, // Status command code being read
  output reg [15:0] o_rd_data, // Read data, low byte for byte reads
  output reg o_rd_hit, // Address names a status register
  input wire i_vout_ov, // Output overvoltage fault present
  input wire i_vout_uv, // Output undervoltage fault present
  input wire i_vout_warn, // Output voltage warning present
  input wire i_vout_req_bad, // Request outside output limits
  input wire i_iout_oc, // Overcurrent fault
  input wire i_iout_oc_uv, // Overcurrent with undervoltage
  input wire i_iout_warn, // Overcurrent warning
  input wire i_uvlo_passed, // Input above lockout threshold
  input wire i_regulation_ok, // Power-good asserted
  input wire i_product_off, // Output disabled
  input wire i_input_overvoltage_pin_fault, // Overvoltage pin sensed
  input wire [VIN_W-1:0] i_vin_meas, // Measured input voltage
  input wire [VIN_W-1:0] i_vin_high_lim, // High warning threshold
  input wire [VIN_W-1:0] i_vin_low_lim, // Low warning threshold
  input wire i_overheat_fault, // Over-temperature fault
  input wire i_overheat_warning, // Over-temperature warning
  input wire i_cmd_bad, // Invalid command seen
  input wire i_data_bad, // Invalid data seen
  input wire i_mem_fault, // Memory fault
  input wire i_cml_other, // Other comm fault
  input wire i_mem_busy, // Memory busy, live
  input wire i_other_fault, // Fault no other bit covers
  output reg o_alert_out_n // Alert, active low
);

  // -------------------------------------------------------------
  // Latched flags
  // -------------------------------------------------------------
  reg vout_maxmin_r;
  reg iout_oc_r;
  reg iout_oc_uv_r;
  reg iout_warn_r;
  reg in_pin_r;
  reg in_high_r;
  reg in_low_r;
  reg overheat_fault_r;
  reg ot_warn_r;
  reg cml_cmd_r;
  reg cml_data_r;
  reg cml_mem_r;
  reg cml_other_r;
  reg other_fault_flag_r;

  // Strict compares: a reading equal to a limit raises no warning
  wire vin_high = i_vin_meas > i_vin_high_lim;
  wire vin_low = i_vin_meas < i_vin_low_lim;

  // Set wins over clear; a cause still present keeps the flag up
  function hold;
    input flag;
    input cause;
    input clr;
    begin
      hold = cause | (flag & ~clr);
    end
  endfunction

  // -------------------------------------------------------------
  // Next values of the latched flags
  // -------------------------------------------------------------
  wire clr = i_clear_faults;
  wire vout_maxmin_nxt = hold(vout_maxmin_r, i_vout_req_bad, clr);
  wire iout_oc_nxt = hold(iout_oc_r, i_iout_oc, clr);
  wire iout_oc_uv_nxt = hold(iout_oc_uv_r, i_iout_oc_uv, clr);
  wire iout_warn_nxt = hold(iout_warn_r, i_iout_warn, clr);
  wire in_pin_nxt = hold(in_pin_r, i_input_overvoltage_pin_fault, clr);
  wire in_high_nxt = hold(in_high_r, vin_high, clr);
  wire in_low_nxt = hold(in_low_r, vin_low, clr);
  wire overheat_fault_nxt = hold(overheat_fault_r, i_overheat_fault, clr);
  wire ot_warn_nxt = hold(ot_warn_r, i_overheat_warning, clr);
  wire cml_cmd_nxt = hold(cml_cmd_r, i_cmd_bad, clr);
  wire cml_data_nxt = hold(cml_data_r, i_data_bad, clr);
  wire cml_mem_nxt = hold(cml_mem_r, i_mem_fault, clr);
  wire cml_other_nxt = hold(cml_other_r, i_cml_other, clr);
  wire other_fault_flag_nxt = hold(other_fault_flag_r, i_other_fault,
    clr);

  // -------------------------------------------------------------
  // Latched flag registers
  // -------------------------------------------------------------
  // One register per flag keeps each clear path easy to follow

  // Output voltage request out of limits
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      vout_maxmin_r <= 1'b0;
    end else begin
      vout_maxmin_r <= vout_maxmin_nxt;
    end
  end

  // Overcurrent fault
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iout_oc_r <= 1'b0;
    end else begin
      iout_oc_r <= iout_oc_nxt;
    end
  end

  // Overcurrent together with output undervoltage
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iout_oc_uv_r <= 1'b0;
    end else begin
      iout_oc_uv_r <= iout_oc_uv_nxt;
    end
  end

  // Overcurrent warning
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      iout_warn_r <= 1'b0;
    end else begin
      iout_warn_r <= iout_warn_nxt;
    end
  end

  // Overvoltage pin
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_pin_r <= 1'b0;
    end else begin
      in_pin_r <= in_pin_nxt;
    end
  end

  // Input high warning
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_high_r <= 1'b0;
    end else begin
      in_high_r <= in_high_nxt;
    end
  end

  // Input low warning
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      in_low_r <= 1'b0;
    end else begin
      in_low_r <= in_low_nxt;
    end
  end

  // Over-temperature fault
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      overheat_fault_r <= 1'b0;
    end else begin
      overheat_fault_r <= overheat_fault_nxt;
    end
  end

  // Over-temperature warning
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      ot_warn_r <= 1'b0;
    end else begin
      ot_warn_r <= ot_warn_nxt;
    end
  end

  // Invalid command
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cml_cmd_r <= 1'b0;
    end else begin
      cml_cmd_r <= cml_cmd_nxt;
    end
  end

  // Invalid data
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cml_data_r <= 1'b0;
    end else begin
      cml_data_r <= cml_data_nxt;
    end
  end

  // Memory fault
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cml_mem_r <= 1'b0;
    end else begin
      cml_mem_r <= cml_mem_nxt;
    end
  end

  // Other communication fault
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cml_other_r <= 1'b0;
    end else begin
      cml_other_r <= cml_other_nxt;
    end
  end

  // Fault that no other bit covers
  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      other_fault_flag_r <= 1'b0;
    end else begin
      other_fault_flag_r <= other_fault_flag_nxt;
    end
  end

  // -------------------------------------------------------------
  // Register images
  // -------------------------------------------------------------
  reg [7:0] byte_img;
  reg [15:0] word_img;
  reg [7:0] vout_img;
  reg [7:0] iout_img;
  reg [7:0] in_img;
  reg [7:0] temp_img;
  reg [7:0] cml_img;

  always @* begin
    // Byte images of the flag registers, spare bits zero
    vout_img = `PFS_RST_BYTE;
    vout_img[`PFS_V_OV] = i_vout_ov;
    vout_img[`PFS_V_UV] = i_vout_uv;
    vout_img[`PFS_V_MAXMIN] = vout_maxmin_r;
    vout_img[`PFS_V_OTHER] = other_fault_flag_r;
    iout_img = `PFS_RST_BYTE;
    iout_img[`PFS_I_OC] = iout_oc_r;
    iout_img[`PFS_I_OC_UV] = iout_oc_uv_r;
    iout_img[`PFS_I_WARN] = iout_warn_r;
    in_img = `PFS_RST_BYTE;
    in_img[`PFS_N_OV_PIN] = in_pin_r;
    in_img[`PFS_N_HIGH] = in_high_r;
    in_img[`PFS_N_LOW] = in_low_r;
    temp_img = `PFS_RST_BYTE;
    temp_img[`PFS_T_FAULT] = overheat_fault_r;
    temp_img[`PFS_T_WARN] = ot_warn_r;
    cml_img = `PFS_RST_BYTE;
    cml_img[`PFS_C_CMD] = cml_cmd_r;
    cml_img[`PFS_C_DATA] = cml_data_r;
    cml_img[`PFS_C_MEM] = cml_mem_r;
    cml_img[`PFS_C_OTHER] = cml_other_r;
    cml_img[`PFS_C_BUSY] = i_mem_busy;
    // Summaries mix live inputs with latched flags
    byte_img = `PFS_RST_BYTE;
    byte_img[`PFS_B_OFF] = i_product_off;
    byte_img[`PFS_B_VOUT_OV] = i_vout_ov;
    byte_img[`PFS_B_IOUT_OC] = iout_oc_r;
    byte_img[`PFS_B_OT] = overheat_fault_r | ot_warn_r;
    byte_img[`PFS_B_CML] = |cml_img[`PFS_C_CMD:`PFS_C_OTHER];
    byte_img[`PFS_B_NONE] = other_fault_flag_r;
    word_img = `PFS_RST_WORD;
    word_img[7:0] = byte_img;
    word_img[`PFS_W_VOUT] = i_vout_ov | i_vout_uv | i_vout_warn;
    word_img[`PFS_W_IOUT] = i_iout_oc | i_iout_oc_uv;
    word_img[`PFS_W_VIN] = ~i_uvlo_passed;
    word_img[`PFS_W_VENDOR] = 1'b0;
    word_img[`PFS_W_PG_N] = ~i_regulation_ok;
    word_img[`PFS_W_OTHER] = other_fault_flag_r;
  end

  // -------------------------------------------------------------
  // Read port, registered
  // -------------------------------------------------------------
  reg [15:0] rd_nxt;
  reg hit_nxt;

  always @* begin
    // Unmapped codes answer zero and no hit
    hit_nxt = 1'b1;
    case (i_rd_addr)
      `PFS_OFF_BYTE: rd_nxt = {8'h00, byte_img};
      `PFS_OFF_WORD: rd_nxt = word_img;
      `PFS_OFF_VOUT: rd_nxt = {8'h00, vout_img};
      `PFS_OFF_IOUT: rd_nxt = {8'h00, iout_img};
      `PFS_OFF_INPUT: rd_nxt = {8'h00, in_img};
      `PFS_OFF_TEMP: rd_nxt = {8'h00, temp_img};
      `PFS_OFF_CML: rd_nxt = {8'h00, cml_img};
      default: begin
        rd_nxt = `PFS_RST_WORD;
        hit_nxt = 1'b0;
      end
    endcase
  end

  // -------------------------------------------------------------
  // Alert output
  // -------------------------------------------------------------
  // Alert follows the latched input, thermal, overcurrent fault, other-fault and invalid-command flags so the host is told to poll
  // Output voltage request flag stays out of the alert by choice
  wire alert_nxt = ~(in_high_r | in_low_r | in_pin_r | iout_oc_r |
    overheat_fault_r | ot_warn_r | other_fault_flag_r |
    cml_img[`PFS_C_CMD]);

  always @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_rd_data <= `PFS_RST_WORD;
      o_rd_hit <= 1'b0;
      o_alert_out_n <= 1'b1;
    end else begin
      o_rd_data <= rd_nxt;
      o_rd_hit <= hit_nxt;
      o_alert_out_n <= alert_nxt;
    end
  end

endmodule // pfs_status_bank
`default_nettype wire

// ==== testbench/pfs_status_props.sv ====
// Port-level checks of the fault status bank
`default_nettype none
module pfs_status_props (
  input wire logic i_clk,
  input wire logic i_rst_b,
  input wire logic [7:0] i_rd_addr,
  input wire logic [15:0] o_rd_data,
  input wire logic i_vout_ov,
  input wire logic i_vout_uv,
  input wire logic i_vout_warn,
  input wire logic i_iout_oc,
  input wire logic i_iout_oc_uv,
  input wire logic i_uvlo_passed,
  input wire logic i_regulation_ok,
  input wire logic i_clear_faults,
  input wire logic i_overheat_fault,
  input wire logic o_alert_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pa_r;
  // Reset to an unmapped code so the first edges after reset check nothing
  always_ff @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b) pa_r <= 8'h00;
    else pa_r <= i_rd_addr;
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_rst_b);
  chk_word_vout: assert property (
    pa_r == 8'h79 |-> o_rd_data[15] == $past(i_vout_ov|i_vout_uv|i_vout_warn))
    else $error("word bit 15 wrong");
  chk_word_iout: assert property (
    pa_r == 8'h79 |-> o_rd_data[14] == $past(i_iout_oc | i_iout_oc_uv))
    else $error("word bit 14 wrong");
  chk_word_vin: assert property (
    pa_r == 8'h79 |-> o_rd_data[13] == !$past(i_uvlo_passed))
    else $error("word bit 13 wrong");
  chk_word_pgood: assert property (
    pa_r == 8'h79 |-> o_rd_data[11] == !$past(i_regulation_ok))
    else $error("word bit 11 wrong");
  chk_vout_live: assert property (
    pa_r == 8'h7a |-> {o_rd_data[7], o_rd_data[4]} == $past({i_vout_ov, i_vout_uv}))
    else $error("output voltage live bits wrong");
  chk_input_zero: assert property (
    pa_r == 8'h7c |-> o_rd_data[4:0] == 5'h00 && o_rd_data[15:8] == 8'h00)
    else $error("input byte spare bits set");
  chk_temp_zero: assert property (
    pa_r == 8'h7d |-> o_rd_data[5:0] == 6'h00)
    else $error("temperature spare bits set");
  chk_alert_set: assert property (
    i_overheat_fault |-> ##2 !o_alert_out_n)
    else $error("alert not raised");
  chk_alert_hold: assert property (
    !o_alert_out_n && !i_clear_faults && !$past(i_clear_faults) |=> !o_alert_out_n)
    else $error("alert dropped without clear");
  cover property (pa_r == 8'h79);
  cover property (!o_alert_out_n && i_clear_faults);
  cover property ($rose(o_alert_out_n));
endmodule // pfs_status_props
bind pfs_status_bank pfs_status_props u_pfs_status_props (.*);
`default_nettype wire

// ==== testbench/pfs_host.sv ====
// Host model: status reads and clear-faults pulses
`default_nettype none
module pfs_host (
  input wire logic i_clk, // Clock
  input wire logic [15:0] i_data, // Read data
  output logic [7:0] o_addr, // Status code
  output logic o_clr // Clear-faults pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_addr = 8'h00;
    o_clr = 1'b0;
  end
  // Byte and word reads share this path; bytes sit in the low half
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge i_clk) o_addr <= a;
    @(posedge i_clk) #1 d = i_data;
  endtask
  task automatic clr;
    @(posedge i_clk) o_clr <= 1'b1;
    @(posedge i_clk) o_clr <= 1'b0;
  endtask
endmodule // pfs_host
`default_nettype wire

// ==== testbench/testbench.sv ====
// Self-checking bench of the fault status bank
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic i_clk = 0, i_rst_b = 0, i_clear_faults, o_rd_hit, o_alert_out_n;
  logic [7:0] i_rd_addr;
  logic [15:0] o_rd_data, d;
  logic i_vout_ov = 0, i_vout_uv = 0, i_vout_warn = 0, i_iout_oc_uv = 0;
  logic i_uvlo_passed = 0, i_regulation_ok = 0, i_product_off = 0;
  logic i_mem_busy = 0, i_other_fault, i_overheat_fault, i_iout_oc;
  logic i_cmd_bad, i_input_overvoltage_pin_fault, i_vout_req_bad;
  logic i_overheat_warning, i_iout_warn, i_data_bad, i_mem_fault, i_cml_other;
  logic [9:0] i_vin_meas = 10'h190, i_vin_high_lim = 10'h258;
  logic [9:0] i_vin_low_lim = 10'h12c;
  logic [10:0] ev = 11'h000;
  logic [7:0] ta [11] = '{8'h7a, 8'h7d, 8'h7b, 8'h7e, 8'h7c, 8'h7a, 8'h7d,
    8'h7b, 8'h7e, 8'h7e, 8'h7e};
  logic [7:0] te [11] = '{8'h01, 8'h80, 8'hc0, 8'h80, 8'h80, 8'h09, 8'hc0,
    8'he0, 8'hc0, 8'hd0, 8'hd2};
  int failures = 0, num_checks = 0;
  assign {i_cml_other, i_mem_fault, i_data_bad, i_iout_warn,
    i_overheat_warning, i_vout_req_bad, i_input_overvoltage_pin_fault,
    i_cmd_bad, i_iout_oc, i_overheat_fault, i_other_fault} = ev;
  pfs_status_bank #(.VIN_W(10)) u_pfs_status_bank (.*);
  pfs_host host (.i_clk(i_clk), .i_data(o_rd_data), .o_addr(i_rd_addr),
    .o_clr(i_clear_faults));
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic rc(input logic [7:0] a, input logic [15:0] e);
    host.rd(a, d);
    chk(d, e);
    chk({15'h0000, o_rd_hit}, {15'h0000, a >= 8'h78 && a <= 8'h7e});
  endtask
  task automatic summarize;
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #2.5 i_clk = ~i_clk;
  // Watchdog; every wait below is a fixed count of edges
  initial begin
    #100us;
    failures++;
    summarize;
  end
  initial begin
    repeat (3) @(posedge i_clk);
    i_rst_b <= 1'b1;
    rc(8'h79, 16'h2800);
    for (int a = 8'h7a; a < 8'h80; a++) rc(a[7:0], 16'h0000);
    @(posedge i_clk) i_uvlo_passed <= 1'b1;
    i_regulation_ok <= 1'b1;
    i_vout_ov <= 1'b1;
    rc(8'h79, 16'h8020);
    rc(8'h7a, 16'h0080);
    @(posedge i_clk) i_vout_ov <= 1'b0;
    i_vout_uv <= 1'b1;
    rc(8'h7a, 16'h0010);
    @(posedge i_clk) i_vout_uv <= 1'b0;
    i_iout_oc_uv <= 1'b1;
    rc(8'h79, 16'h4000);
    @(posedge i_clk) i_iout_oc_uv <= 1'b0;
    i_vout_warn <= 1'b1;
    i_product_off <= 1'b1;
    i_mem_busy <= 1'b1;
    rc(8'h79, 16'h8040);
    rc(8'h7e, 16'h0001);
    @(posedge i_clk) i_vout_warn <= 1'b0;
    i_product_off <= 1'b0;
    i_mem_busy <= 1'b0;
    for (int i = 0; i < 11; i++) begin
      @(posedge i_clk) ev <= 11'h001 << i;
      @(posedge i_clk) ev <= 11'h000;
      rc(ta[i], {8'h00, te[i]});
    end
    rc(8'h78, 16'h0017);
    rc(8'h79, 16'h0117);
    @(posedge i_clk) i_vin_meas <= 10'h259;
    @(posedge i_clk) i_vin_meas <= 10'h258;
    rc(8'h7c, 16'h00c0);
    @(posedge i_clk) i_vin_meas <= 10'h12b;
    @(posedge i_clk) i_vin_meas <= 10'h12c;
    rc(8'h7c, 16'h00e0);
    chk({15'h0000, o_alert_out_n}, 16'h0000);
    @(posedge i_clk) ev <= 11'h040;
    host.clr();
    rc(8'h7d, 16'h0040);
    @(posedge i_clk) ev <= 11'h000;
    host.clr();
    for (int a = 8'h78; a < 8'h7f; a++) rc(a[7:0], 16'h0000);
    chk({15'h0000, o_alert_out_n}, 16'h0001);
    summarize;
  end
endmodule // testbench
`default_nettype wire
